// ---- hdl/mioef_defines.vh ----
// Register map, field positions and reset values of the E/F port block.
// Assumes a 32-bit AHB-Lite bus with one aligned word per register.
`ifndef MIOEF_DEFINES_VH
`define MIOEF_DEFINES_VH

// Byte offsets, decoded on the low address byte
`define MIOEF_OFS_PIN_LEVEL_E    8'h00
`define MIOEF_OFS_OUT_LATCH_E    8'h04
`define MIOEF_OFS_DIRECTION_E    8'h08
`define MIOEF_OFS_PIN_LEVEL_F    8'h0C
`define MIOEF_OFS_OUT_LATCH_F    8'h10
`define MIOEF_OFS_DIRECTION_F    8'h14
`define MIOEF_OFS_ANALOG_SEL_F   8'h18
`define MIOEF_OFS_SEGMENT_EN     8'h1C
`define MIOEF_OFS_CMP_CONTROL    8'h20
`define MIOEF_OFS_STATUS         8'h24

// Address decode width
`define MIOEF_ADDR_LSB_W         8

// Reset values
`define MIOEF_RST_LATCH_E        8'h00
`define MIOEF_RST_DIR_E          8'hFF
`define MIOEF_RST_LATCH_F        7'h00
`define MIOEF_RST_DIR_F          7'h7F
`define MIOEF_RST_ANALOG_F       7'h7F
`define MIOEF_RST_SEG_F          7'h00
`define MIOEF_RST_SEG_E7         1'h0
`define MIOEF_RST_CMP            3'h0

// Field positions
`define MIOEF_SEG_E7_BIT         0
`define MIOEF_CMP_ONE_OE_BIT     0
`define MIOEF_CMP_TWO_OE_BIT     1
`define MIOEF_CMP_ON_BIT         2
`define MIOEF_ST_ROUTED_BIT      0
`define MIOEF_ST_SHUTDOWN_BIT    1

// Pin index of the shared capture pin inside port E
`define MIOEF_E_CAPTURE_PIN      7

// F pins 3..6 that carry comparator inputs; vector bit 0 is pin 1
`define MIOEF_CMP_INPUT_PINS     7'h3C

// AHB encodings
`define MIOEF_HRESP_OKAY         1'h0

`endif

// ---- hdl/mioef_sync.v ----
// Two-flop synchroniser for a vector of pad inputs.
// Assumes each bit is an independent level; no bus coherence is implied.
`timescale 1ns/1ps

module mioef_sync #(
  parameter WIDTH = 15
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut_r
);

  reg [WIDTH-1:0] stage1_r;

  // First stage is read only by the second stage
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_r  <= {WIDTH{1'b0}};
      syncOut_r <= {WIDTH{1'b0}};
    end else begin
      stage1_r  <= asyncIn;
      syncOut_r <= stage1_r;
    end
  end

endmodule // mioef_sync

// ---- hdl/mioef_pin_cell.v ----
// Combinational function mux of one port pin.
// Assumes the pad input is already synchronised; the caller registers results.
`timescale 1ns/1ps

module mioef_pin_cell (
  input  wire latchBit,
  input  wire dirBit,
  input  wire segEn,
  input  wire inputBlock,
  input  wire altEn,
  input  wire altData,
  input  wire altTristate,
  input  wire pinSync,
  output wire pinOut,
  output wire pinOe,
  output wire readBit
);

  // Segment drive wins over everything, direction then ignored
  assign pinOe   = ~segEn & ~dirBit & ~(altEn & altTristate);
  // Peripheral data takes priority over latch data when driving
  assign pinOut  = altEn ? altData : latchBit;
  // Digital input gated by analog select and segment drive
  assign readBit = pinSync & ~inputBlock & ~segEn;

endmodule // mioef_pin_cell

// ---- hdl/mioef_port.v ----
// E/F port pin logic: direction, latches, pin reads, function ownership.
// Assumes a single AHB-Lite master with this slave as the only hready source.
`timescale 1ns/1ps
`include "mioef_defines.vh"

module mioef_port (
  input  wire        clk,
  input  wire        reset_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout_r,
  output reg         hresp_r,
  output reg  [31:0] hrdata_r,
  // Port E pads
  input  wire [7:0]  portEIn,
  output reg  [7:0]  portEOut_r,
  output reg  [7:0]  portEOe_r,
  // Port F pads, pins 7 to 1
  input  wire [7:1]  portFIn,
  output reg  [7:1]  portFOut_r,
  output reg  [7:1]  portFOe_r,
  // Enhanced capture unit two
  input  wire        capturePinSelect,
  input  wire        eccpOutputMode,
  input  wire        eccpCompareOut,
  input  wire        eccpShutdownTristate,
  output reg         eccpCaptureIn_r,
  // Comparators
  input  wire        comparatorOneOutput,
  input  wire        comparatorTwoOutput,
  output reg         comparatorsOn_r,
  // Analog connection of each F pin to the converter and comparators
  output reg  [7:1]  analogConnectF_r
);

  localparam NPIN = 15;

  // Software visible state
  reg  [7:0]  latchE_r;
  reg  [7:0]  dirE_r;
  reg  [7:1]  latchF_r;
  reg  [7:1]  dirF_r;
  reg  [7:1]  analogSelF_r;
  reg  [7:1]  segF_r;
  reg         segE7_r;
  reg  [2:0]  cmpCtl_r;

  // Next values after a pending write
  reg  [7:0]  latchE_nxt;
  reg  [7:0]  dirE_nxt;
  reg  [7:1]  latchF_nxt;
  reg  [7:1]  dirF_nxt;
  reg  [7:1]  analogSelF_nxt;
  reg  [7:1]  segF_nxt;
  reg         segE7_nxt;
  reg  [2:0]  cmpCtl_nxt;

  // Bus data phase bookkeeping
  reg         wrPend_r;
  reg  [7:0]  wrAddr_r;
  reg  [31:0] rdMux;
  wire        addrPhase;
  wire [7:0]  rdAddr;

  // Pin cell vectors, E pins at 0..7, F pin k at 7+k
  wire [NPIN-1:0] pinSync;
  wire [NPIN-1:0] latchAll;
  wire [NPIN-1:0] dirAll;
  wire [NPIN-1:0] segAll;
  wire [NPIN-1:0] blockAll;
  wire [NPIN-1:0] altEnAll;
  wire [NPIN-1:0] altDataAll;
  wire [NPIN-1:0] altTriAll;
  wire [NPIN-1:0] cellOut;
  wire [NPIN-1:0] cellOe;
  wire [NPIN-1:0] cellRead;

  wire        eccpRouted;
  wire        eccpDrives;
  wire        cmpOneOe;
  wire        cmpTwoOe;
  wire        cmpOn;
  wire [7:1]  inputBlockF;

  // Pad inputs come from outside the clock domain
  mioef_sync #(
    .WIDTH (NPIN)
  ) u_sync (
    .clk       (clk),
    .reset_n   (reset_n),
    .asyncIn   ({portFIn, portEIn}),
    .syncOut_r (pinSync)
  );

  // Capture unit owns E7 only with the select bit cleared
  assign eccpRouted = ~capturePinSelect;
  assign eccpDrives = eccpRouted & eccpOutputMode;
  assign cmpOneOe   = cmpCtl_r[`MIOEF_CMP_ONE_OE_BIT];
  assign cmpTwoOe   = cmpCtl_r[`MIOEF_CMP_TWO_OE_BIT];
  assign cmpOn      = cmpCtl_r[`MIOEF_CMP_ON_BIT];

  // Comparator inputs on pins 3..6 also starve the digital input
  assign inputBlockF = analogSelF_r | ({7{cmpOn}} & `MIOEF_CMP_INPUT_PINS);

  // Gather per-pin controls
  assign latchAll   = {latchF_r, latchE_r};
  assign dirAll     = {dirF_r, dirE_r};
  assign segAll     = {segF_r, segE7_r, 7'h00};
  assign blockAll   = {inputBlockF, 8'h00};
  assign altEnAll   = {5'h00, cmpOneOe, cmpTwoOe, eccpDrives, 7'h00};
  assign altDataAll = {5'h00, comparatorOneOutput, comparatorTwoOutput,
                       eccpCompareOut, 7'h00};
  assign altTriAll  = {7'h00, eccpShutdownTristate, 7'h00};

  // One mux cell per pin
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
      mioef_pin_cell u_cell (
        .latchBit    (latchAll[gi]),
        .dirBit      (dirAll[gi]),
        .segEn       (segAll[gi]),
        .inputBlock  (blockAll[gi]),
        .altEn       (altEnAll[gi]),
        .altData     (altDataAll[gi]),
        .altTristate (altTriAll[gi]),
        .pinSync     (pinSync[gi]),
        .pinOut      (cellOut[gi]),
        .pinOe       (cellOe[gi]),
        .readBit     (cellRead[gi])
      );
    end
  endgenerate

  // AHB address phase; only NONSEQ or SEQ transfers count
  assign addrPhase = hsel & htrans[1] & hready;
  assign rdAddr    = haddr[`MIOEF_ADDR_LSB_W-1:0];

  // Write data arrives one cycle after its address phase
  always @* begin
    latchE_nxt     = latchE_r;
    dirE_nxt       = dirE_r;
    latchF_nxt     = latchF_r;
    dirF_nxt       = dirF_r;
    analogSelF_nxt = analogSelF_r;
    segF_nxt       = segF_r;
    segE7_nxt      = segE7_r;
    cmpCtl_nxt     = cmpCtl_r;
    if (wrPend_r) begin
      case (wrAddr_r)
        `MIOEF_OFS_PIN_LEVEL_E,
        `MIOEF_OFS_OUT_LATCH_E: begin
          latchE_nxt = hwdata[7:0];
        end
        `MIOEF_OFS_DIRECTION_E: begin
          dirE_nxt = hwdata[7:0];
        end
        `MIOEF_OFS_PIN_LEVEL_F,
        `MIOEF_OFS_OUT_LATCH_F: begin
          latchF_nxt = hwdata[7:1];
        end
        `MIOEF_OFS_DIRECTION_F: begin
          dirF_nxt = hwdata[7:1];
        end
        `MIOEF_OFS_ANALOG_SEL_F: begin
          analogSelF_nxt = hwdata[7:1];
        end
        `MIOEF_OFS_SEGMENT_EN: begin
          segF_nxt  = hwdata[7:1];
          segE7_nxt = hwdata[`MIOEF_SEG_E7_BIT];
        end
        `MIOEF_OFS_CMP_CONTROL: begin
          cmpCtl_nxt = hwdata[2:0];
        end
        default: begin
          // Unmapped or read-only: write ignored, still OKAY
          latchE_nxt = latchE_r;
        end
      endcase
    end
  end

  // Read mux uses next values so a read right after a write sees it
  always @* begin
    rdMux = 32'h0000_0000;
    case (rdAddr)
      `MIOEF_OFS_PIN_LEVEL_E:  rdMux[7:0] = cellRead[7:0];
      `MIOEF_OFS_OUT_LATCH_E:  rdMux[7:0] = latchE_nxt;
      `MIOEF_OFS_DIRECTION_E:  rdMux[7:0] = dirE_nxt;
      `MIOEF_OFS_PIN_LEVEL_F:  rdMux[7:1] = cellRead[NPIN-1:8];
      `MIOEF_OFS_OUT_LATCH_F:  rdMux[7:1] = latchF_nxt;
      `MIOEF_OFS_DIRECTION_F:  rdMux[7:1] = dirF_nxt;
      `MIOEF_OFS_ANALOG_SEL_F: rdMux[7:1] = analogSelF_nxt;
      `MIOEF_OFS_SEGMENT_EN: begin
        rdMux[7:1]                = segF_nxt;
        rdMux[`MIOEF_SEG_E7_BIT]  = segE7_nxt;
      end
      `MIOEF_OFS_CMP_CONTROL:  rdMux[2:0] = cmpCtl_nxt;
      `MIOEF_OFS_STATUS: begin
        rdMux[`MIOEF_ST_ROUTED_BIT]   = eccpRouted;
        rdMux[`MIOEF_ST_SHUTDOWN_BIT] = eccpShutdownTristate;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Bus slave: zero wait states, always OKAY
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_r    <= 1'b0;
      wrAddr_r    <= 8'h00;
      hrdata_r    <= 32'h0000_0000;
      hreadyout_r <= 1'b0;
      hresp_r     <= `MIOEF_HRESP_OKAY;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= `MIOEF_HRESP_OKAY;
      wrPend_r    <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_r <= rdAddr;
      end
      if (addrPhase & ~hwrite) begin
        hrdata_r <= rdMux;
      end
    end
  end

  // Register file; F pins come up analog inputs with direction one
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latchE_r     <= `MIOEF_RST_LATCH_E;
      dirE_r       <= `MIOEF_RST_DIR_E;
      latchF_r     <= `MIOEF_RST_LATCH_F;
      dirF_r       <= `MIOEF_RST_DIR_F;
      analogSelF_r <= `MIOEF_RST_ANALOG_F;
      segF_r       <= `MIOEF_RST_SEG_F;
      segE7_r      <= `MIOEF_RST_SEG_E7;
      cmpCtl_r     <= `MIOEF_RST_CMP;
    end else begin
      latchE_r     <= latchE_nxt;
      dirE_r       <= dirE_nxt;
      latchF_r     <= latchF_nxt;
      dirF_r       <= dirF_nxt;
      analogSelF_r <= analogSelF_nxt;
      segF_r       <= segF_nxt;
      segE7_r      <= segE7_nxt;
      cmpCtl_r     <= cmpCtl_nxt;
    end
  end

  // Pad drivers registered; adds one cycle but keeps pads glitch free
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      portEOut_r <= 8'h00;
      portEOe_r  <= 8'h00;
      portFOut_r <= 7'h00;
      portFOe_r  <= 7'h00;
    end else begin
      portEOut_r <= cellOut[7:0];
      portEOe_r  <= cellOe[7:0];
      portFOut_r <= cellOut[NPIN-1:8];
      portFOe_r  <= cellOe[NPIN-1:8];
    end
  end

  // Peripheral side: capture input and analog hookup
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eccpCaptureIn_r  <= 1'b0;
      comparatorsOn_r  <= 1'b0;
      analogConnectF_r <= 7'h00;
    end else begin
      // Capture needs E7 routed, set as input, segment off
      eccpCaptureIn_r  <= eccpRouted & dirE_r[`MIOEF_E_CAPTURE_PIN] &
                          cellRead[`MIOEF_E_CAPTURE_PIN];
      comparatorsOn_r  <= cmpOn;
      // Segment drive also cuts the analog path
      analogConnectF_r <= inputBlockF & ~segF_r;
    end
  end

endmodule // mioef_port

// ---- verification/mioef_port_assertions.sv ----
// Checker of the E/F port block, watching only top-level ports.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps

module mioef_port_assertions (
  input wire        clk,
  input wire        reset_n,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout_r,
  input wire        hresp_r,
  input wire [31:0] hrdata_r,
  input wire [7:0]  portEOut_r,
  input wire [7:0]  portEOe_r,
  input wire [7:1]  portFOe_r,
  input wire        capturePinSelect,
  input wire        eccpOutputMode,
  input wire        eccpCompareOut,
  input wire        eccpShutdownTristate,
  input wire        eccpCaptureIn_r,
  input wire [7:1]  analogConnectF_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Bus answers at once and always OKAY
  AST_OKAY_RESP: assert property (hresp_r == 1'b0)
    else $error("response not OKAY");
  AST_ZERO_WAIT: assert property ($past(reset_n) |-> hreadyout_r)
    else $error("slave inserted a wait state");
  // Read data only moves after a read address phase
  AST_RDATA_HOLD: assert property (!(hsel && htrans[1] && hready && !hwrite)
    |=> $stable(hrdata_r))
    else $error("read data changed without a read");
  // First edge after release: analog on, nothing driven
  AST_RESET_ANALOG: assert property ($rose(hreadyout_r) |->
    analogConnectF_r == 7'h7F && portFOe_r == 7'h00 && portEOe_r == 8'h00)
    else $error("reset state of pins wrong");
  AST_CAPTURE_UNROUTED: assert property (capturePinSelect |=> !eccpCaptureIn_r)
    else $error("capture input seen while unrouted");
  AST_SHUTDOWN_TRISTATE: assert property (!capturePinSelect && eccpOutputMode
    && eccpShutdownTristate |=> !portEOe_r[7])
    else $error("PWM output driven during shutdown");
  AST_COMPARE_DRIVES: assert property ((!capturePinSelect && eccpOutputMode)
    ##1 portEOe_r[7] |-> portEOut_r[7] == $past(eccpCompareOut))
    else $error("capture unit output not on pin");
  AST_CAPTURE_NOT_DRIVEN: assert property (eccpCaptureIn_r |-> !portEOe_r[7])
    else $error("capture pin driven while capturing");
endmodule // mioef_port_assertions

bind mioef_port mioef_port_assertions u_chk (.clk, .reset_n, .hsel, .htrans, .hwrite,
  .hready, .hreadyout_r, .hresp_r, .hrdata_r, .portEOut_r, .portEOe_r, .portFOe_r,
  .capturePinSelect, .eccpOutputMode, .eccpCompareOut, .eccpShutdownTristate,
  .eccpCaptureIn_r, .analogConnectF_r);

// ---- verification/mioef_pad_model.sv ----
// Board side of the E/F pads: resolves each wire from both drivers.
// Assumes the board drives every pin that the block leaves undriven.
`timescale 1ns/1ps

module mioef_pad_model (
  input  wire [7:0] eOut,
  input  wire [7:0] eOe,
  input  wire [7:0] eExt,
  input  wire [7:1] fOut,
  input  wire [7:1] fOe,
  input  wire [7:1] fExt,
  output wire [7:0] eIn,
  output wire [7:1] fIn
);
  // Each pin bidirectional: the block wins where it drives
  assign eIn = (eOut & eOe) | (eExt & ~eOe);
  assign fIn = (fOut & fOe) | (fExt & ~fOe);
endmodule // mioef_pad_model

// ---- verification/mioef_port_tb.sv ----
// Self-checking bench of the E/F port block with an AHB-Lite master.
// Assumes the block is the only slave and drives hready.
`timescale 1ns/1ps
`include "mioef_defines.vh"

module multiplexed_io_port_f_e_tb;
  logic        clk = 0, reset_n = 0, hsel = 0, hwrite = 0, cps = 1, mode = 0;
  logic        cmpOut = 0, shut = 0, c1 = 0, c2 = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [7:0]  eExt = 0, eIn, lat, dir, m;
  logic [7:1]  fExt = 7'h7F, fIn;
  wire         hready;
  wire  [31:0] hrdata_r;
  wire  [7:0]  portEOut_r, portEOe_r;
  wire  [7:1]  portFOut_r, portFOe_r, analogConnectF_r;
  wire         hresp_r, eccpCaptureIn_r, comparatorsOn_r;
  int          mismatches = 0, tests_run = 0, cycles = 0, p, i;

  always #12.5 clk = ~clk;

  mioef_port DUT (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hreadyout_r(hready), .hresp_r, .hrdata_r, .portEIn(eIn), .portEOut_r,
    .portEOe_r, .portFIn(fIn), .portFOut_r, .portFOe_r, .capturePinSelect(cps),
    .eccpOutputMode(mode), .eccpCompareOut(cmpOut), .eccpShutdownTristate(shut),
    .eccpCaptureIn_r, .comparatorOneOutput(c1), .comparatorTwoOutput(c2),
    .comparatorsOn_r, .analogConnectF_r);
  mioef_pad_model u_pads (.eOut(portEOut_r), .eOe(portEOe_r), .eExt, .fOut(portFOut_r),
    .fOe(portFOe_r), .fExt, .eIn, .fIn);

  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chkPad(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One single transfer; waits on hready at each phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata_r;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d});
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] expPin(input logic [7:0] l, d, x);
    return (l & ~d) | (x & d);
  endfunction

  initial begin
    p = $urandom(12386);
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    eExt <= 8'hA5;
    settle();
    // Reset values, F reads zero while analog, unmapped reads zero
    bus(0, `MIOEF_OFS_OUT_LATCH_E, 0); chkReg(rd, 32'h00);
    bus(0, `MIOEF_OFS_DIRECTION_E, 0); chkReg(rd, 32'hFF);
    bus(0, `MIOEF_OFS_DIRECTION_F, 0); chkReg(rd, 32'hFE);
    bus(0, `MIOEF_OFS_ANALOG_SEL_F, 0); chkReg(rd, 32'hFE);
    bus(0, `MIOEF_OFS_PIN_LEVEL_F, 0); chkReg(rd, 32'h00);
    bus(0, `MIOEF_OFS_PIN_LEVEL_E, 0); chkReg(rd, 32'hA5);
    bus(0, 8'h30, 0); chkReg(rd, 32'h00);
    // Digital setup: comparators off, analog cleared
    wr(`MIOEF_OFS_CMP_CONTROL, 8'h00);
    wr(`MIOEF_OFS_ANALOG_SEL_F, 8'h00);
    // Random latch and direction on both ports, E7 alternate unrouted
    for (i = 0; i < 12; i++) begin
      p = i % 2;
      m = p ? 8'hFE : 8'hFF;
      lat = 8'($urandom) & m;
      dir = (i < 2) ? 8'h00 : (i < 4) ? 8'hFF : 8'($urandom);
      eExt <= 8'($urandom);
      fExt <= 7'($urandom);
      mode <= 1'($urandom);
      cmpOut <= 1'($urandom);
      shut <= 1'($urandom);
      // Latch reached through both the pin-level and the latch offset
      wr(p ? (i[1] ? 8'h0C : 8'h10) : (i[1] ? 8'h04 : 8'h00), lat);
      wr(p ? 8'h14 : 8'h08, dir);
      settle();
      chkPad(p ? {portFOe_r, 1'b0} : portEOe_r, ~dir & m);
      chkPad((p ? {portFOut_r, 1'b0} : portEOut_r) & ~dir & m, lat & ~dir);
      bus(0, p ? 8'h10 : 8'h04, 0); chkReg(rd, {24'h0, lat});
      bus(0, p ? 8'h0C : 8'h00, 0);
      chkReg(rd, {24'h0, expPin(lat, dir, p ? {fExt, 1'b0} : eExt) & m});
    end
    // Analog on with outputs: latch still drives, reads zero
    wr(`MIOEF_OFS_DIRECTION_F, 8'h00);
    wr(`MIOEF_OFS_OUT_LATCH_F, 8'h5A);
    wr(`MIOEF_OFS_ANALOG_SEL_F, 8'hFE);
    settle();
    chkPad({portFOut_r, portFOe_r[1]}, 8'h5B);
    chkPad({analogConnectF_r, 1'b0}, 8'hFE);
    bus(0, `MIOEF_OFS_PIN_LEVEL_F, 0); chkReg(rd, 32'h0);
    // All segments on, E7 output direction
    wr(`MIOEF_OFS_DIRECTION_E, 8'h00);
    wr(`MIOEF_OFS_SEGMENT_EN, 8'hFF);
    settle();
    chkPad({portEOe_r[7], portFOe_r}, 8'h00);
    chkPad({analogConnectF_r, 1'b0}, 8'h00);
    bus(0, `MIOEF_OFS_PIN_LEVEL_F, 0); chkReg(rd, 32'h0);
    wr(`MIOEF_OFS_SEGMENT_EN, 8'h00);
    wr(`MIOEF_OFS_ANALOG_SEL_F, 8'h00);
    // Comparator outputs override latch on F1 and F2
    for (i = 0; i < 4; i++) begin
      c1 <= i[0];
      c2 <= i[1];
      wr(`MIOEF_OFS_CMP_CONTROL, 8'h03);
      settle();
      chkPad({portFOut_r[2:1], portFOe_r[2:1]}, {4'h0, i[0], i[1], 2'h3});
    end
    // Comparators on: F3..F6 read zero as inputs
    wr(`MIOEF_OFS_CMP_CONTROL, 8'h04);
    wr(`MIOEF_OFS_DIRECTION_F, 8'hFE);
    fExt <= 7'h7F;
    settle();
    chkPad({7'h0, comparatorsOn_r}, 8'h01);
    bus(0, `MIOEF_OFS_PIN_LEVEL_F, 0); chkReg(rd, 32'h86);
    // Capture unit routed to E7: compare output, shutdown, capture
    cps <= 1'b0;
    mode <= 1'b1;
    shut <= 1'b0;
    wr(`MIOEF_OFS_DIRECTION_E, 8'h7F);
    for (i = 0; i < 2; i++) begin
      cmpOut <= i[0];
      settle();
      chkPad({portEOut_r[7], portEOe_r[7]}, {6'h0, i[0], 1'b1});
    end
    shut <= 1'b1;
    settle();
    chkPad({7'h0, portEOe_r[7]}, 8'h00);
    bus(0, `MIOEF_OFS_STATUS, 0); chkReg(rd, 32'h3);
    mode <= 1'b0;
    eExt <= 8'h80;
    wr(`MIOEF_OFS_DIRECTION_E, 8'hFF);
    settle();
    chkPad({7'h0, eccpCaptureIn_r}, 8'h01);
    cps <= 1'b1;
    settle();
    chkPad({7'h0, eccpCaptureIn_r}, 8'h00);
    print_verdict();
  end
endmodule // multiplexed_io_port_f_e_tb
